// ==== nvsc_pkg.sv ====
// constants, state type and timing counts of the store/recall controller
// assumes a single 50 MHz core clock; long counts are overridden at the top
package nvsc_pkg;

  // ****************************************
  // clock and widths
  // ****************************************
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CNT_W   = 20;

  // ****************************************
  // times as printed, in their own units
  // ****************************************
  localparam int unsigned RECALL_UP_MS = 20;  // restore after power-up
  localparam int unsigned STORE_MS     = 8;   // nonvolatile save
  localparam int unsigned WR_HOLD_NS   = 25;  // write window after a power-fail trigger
  localparam int unsigned RECALL_US    = 600; // commanded restore
  localparam int unsigned CMD_ACT_US   = 500; // latest start of a special-function command
  localparam int unsigned SLEEP_MS     = 8;   // entry into low power
  localparam int unsigned WAKE_MS      = 20;  // wake from sleep
  localparam int unsigned STANDBY_US   = 100; // standby after stop

  // ****************************************
  // derived cycle counts (the write hold rounds down, at least one cycle)
  // ****************************************
  localparam int unsigned RECALL_UP_CYC = RECALL_UP_MS * 1000 * CLK_MHZ;
  localparam int unsigned STORE_CYC     = STORE_MS * 1000 * CLK_MHZ;
  localparam int unsigned WR_HOLD_RAW   = (WR_HOLD_NS * CLK_MHZ) / 1000;
  localparam int unsigned WR_HOLD_CYC   = (WR_HOLD_RAW < 1) ? 1 : WR_HOLD_RAW;
  localparam int unsigned RECALL_CYC    = RECALL_US * CLK_MHZ;
  localparam int unsigned CMD_ACT_CYC   = CMD_ACT_US * CLK_MHZ;
  localparam int unsigned SLEEP_CYC     = SLEEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned WAKE_CYC      = WAKE_MS * 1000 * CLK_MHZ;
  localparam int unsigned STANDBY_CYC   = STANDBY_US * CLK_MHZ;

  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [3:0] {
    NVSC_POWER_LOW,
    NVSC_UP_RECALL,
    NVSC_IDLE,
    NVSC_SW_STORE,
    NVSC_SW_RECALL,
    NVSC_SLEEP_ENTER,
    NVSC_SLEEP,
    NVSC_WAKE,
    NVSC_PF_HOLD,
    NVSC_PF_STORE
  } nvsc_state_type;

endpackage

// ==== nvsc_timer.sv ====
// one-shot down counter used for every timed interval of the controller
// assumes load is a single-cycle pulse from logic on the same clock
`timescale 1ns/1ns
module nvsc_timer (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // control
  input  wire logic                       load,
  input  wire logic [nvsc_pkg::CNT_W-1:0] load_val,
  input  wire logic                       abort,
  // status
  output logic                            done
);
  import nvsc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic             run_r;

  // ****************************************
  // count down, done pulses on the last cycle
  // ****************************************
  // a load in the abort cycle wins, so the power-fail hold can start in the very
  // cycle that aborts the interval before it; otherwise that hold would never end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= load_val;
      run_r <= 1'b1;
    end else if (abort) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 1'b1;
      if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
        run_r <= 1'b0;
      end
    end
  end

  // a load of one ends after one cycle; zero is never loaded
  assign done = run_r && (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule

// ==== nvsc_ctrl.sv ====
// power-up restore, power-fail save, commanded save/restore, sleep and standby control
// assumes bus command strobes come from a serial bus decoder on core_clk;
// the supply flag comes from an analogue comparator and is asynchronous
`timescale 1ns/1ns
module nvsc_ctrl #(
  parameter logic [nvsc_pkg::CNT_W-1:0] RECALL_UP_CYC = nvsc_pkg::CNT_W'(nvsc_pkg::RECALL_UP_CYC),
  parameter logic [nvsc_pkg::CNT_W-1:0] STORE_CYC     = nvsc_pkg::CNT_W'(nvsc_pkg::STORE_CYC),
  parameter logic [nvsc_pkg::CNT_W-1:0] RECALL_CYC    = nvsc_pkg::CNT_W'(nvsc_pkg::RECALL_CYC),
  parameter logic [nvsc_pkg::CNT_W-1:0] CMD_ACT_CYC   = nvsc_pkg::CNT_W'(nvsc_pkg::CMD_ACT_CYC),
  parameter logic [nvsc_pkg::CNT_W-1:0] SLEEP_CYC     = nvsc_pkg::CNT_W'(nvsc_pkg::SLEEP_CYC),
  parameter logic [nvsc_pkg::CNT_W-1:0] WAKE_CYC      = nvsc_pkg::CNT_W'(nvsc_pkg::WAKE_CYC),
  parameter logic [nvsc_pkg::CNT_W-1:0] STANDBY_CYC   = nvsc_pkg::CNT_W'(nvsc_pkg::STANDBY_CYC)
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // supply comparator, high while supply is above the trigger level
  input  wire logic supply_ok,
  // bus decoder events, one-cycle pulses
  input  wire logic bus_start,
  input  wire logic bus_stop,
  input  wire logic cmd_store,
  input  wire logic cmd_recall,
  input  wire logic cmd_sleep,
  input  wire logic sram_wr_done,
  // access gating to the array and bus slave
  output logic      rd_en,
  output logic      wr_en,
  output logic      busy,
  // nonvolatile engine strobes, one-cycle pulses
  output logic      nv_store_go,
  output logic      nv_recall_go,
  // power state
  output logic      sleep_mode,
  output logic      standby_mode,
  output logic      dirty
);
  import nvsc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  nvsc_state_type   state_r;
  nvsc_state_type   state_nxt;
  logic [2:0]       sup_sync_r;
  logic             sup_r;
  logic             dirty_r;
  logic             t_load;
  logic [CNT_W-1:0] t_val;
  logic             t_done;
  logic             sb_load;
  logic             sb_done;
  logic             power_fail;
  logic [CNT_W-1:0] hold_val;

  assign hold_val = CNT_W'(WR_HOLD_CYC);

  // ****************************************
  // supply flag synchroniser
  // ****************************************
  // three stages; the level only moves once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sup_sync_r <= 3'h0;
      sup_r      <= 1'b0;
    end else begin
      sup_sync_r <= {sup_sync_r[1:0], supply_ok};
      if (sup_sync_r[1] == sup_sync_r[2]) begin
        sup_r <= sup_sync_r[2];
      end
    end
  end

  // supply loss preempts every state except power-low and a power-fail hold or save already under way
  assign power_fail = !sup_r && (state_r != NVSC_POWER_LOW) && (state_r != NVSC_PF_HOLD)
                      && (state_r != NVSC_PF_STORE);

  // ****************************************
  // written-since-last-save tracking
  // ****************************************
  // a write landing in the clearing cycle keeps the flag set
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dirty_r <= 1'b0;
    end else if (sram_wr_done) begin
      dirty_r <= 1'b1;
    end else if (nv_store_go_now() || nv_recall_go_now()) begin
      dirty_r <= 1'b0;
    end
  end

  function automatic logic nv_store_go_now();
    nv_store_go_now = (state_nxt == NVSC_PF_STORE || state_nxt == NVSC_SW_STORE
                       || state_nxt == NVSC_SLEEP_ENTER) && (state_nxt != state_r);
  endfunction

  function automatic logic nv_recall_go_now();
    nv_recall_go_now = (state_nxt == NVSC_UP_RECALL || state_nxt == NVSC_SW_RECALL)
                       && (state_nxt != state_r);
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    t_load    = 1'b0;
    t_val     = STORE_CYC;
    if (power_fail) begin
      if (dirty_r) begin
        state_nxt = NVSC_PF_HOLD;
        t_load    = 1'b1;
        t_val     = hold_val;
      end else begin
        state_nxt = NVSC_POWER_LOW;
      end
    end else begin
      unique case (state_r)
        NVSC_POWER_LOW: begin
          if (sup_r) begin
            state_nxt = NVSC_UP_RECALL;
            t_load    = 1'b1;
            t_val     = RECALL_UP_CYC;
          end
        end
        NVSC_UP_RECALL: begin
          if (t_done) begin
            state_nxt = NVSC_IDLE;
          end
        end
        NVSC_IDLE: begin
          // commands act on the next edge, well inside CMD_ACT_CYC
          if (sup_r && cmd_store) begin
            state_nxt = NVSC_SW_STORE;
            t_load    = 1'b1;
            t_val     = STORE_CYC;
          end else if (sup_r && cmd_recall) begin
            state_nxt = NVSC_SW_RECALL;
            t_load    = 1'b1;
            t_val     = RECALL_CYC;
          end else if (sup_r && cmd_sleep) begin
            state_nxt = NVSC_SLEEP_ENTER;
            t_load    = 1'b1;
            t_val     = SLEEP_CYC;
          end
        end
        NVSC_SW_STORE, NVSC_SW_RECALL: begin
          if (t_done) begin
            state_nxt = NVSC_IDLE;
          end
        end
        NVSC_SLEEP_ENTER: begin
          if (t_done) begin
            state_nxt = NVSC_SLEEP;
          end
        end
        NVSC_SLEEP: begin
          if (bus_start) begin
            state_nxt = NVSC_WAKE;
            t_load    = 1'b1;
            t_val     = WAKE_CYC;
          end
        end
        NVSC_WAKE: begin
          if (t_done) begin
            state_nxt = NVSC_IDLE;
          end
        end
        NVSC_PF_HOLD: begin
          if (t_done) begin
            state_nxt = NVSC_PF_STORE;
            t_load    = 1'b1;
            t_val     = STORE_CYC;
          end
        end
        NVSC_PF_STORE: begin
          // the save runs on the capacitor even if the supply returns
          if (t_done) begin
            state_nxt = NVSC_POWER_LOW;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= NVSC_POWER_LOW;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // interval timers
  // ****************************************
  nvsc_timer u_seq_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (t_load),
    .load_val (t_val),
    .abort    (power_fail),
    .done     (t_done)
  );

  // standby countdown restarts on every stop while idle
  assign sb_load = bus_stop && (state_r == NVSC_IDLE);

  nvsc_timer u_standby_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (sb_load),
    .load_val (STANDBY_CYC),
    .abort    (bus_start || (state_r != NVSC_IDLE)),
    .done     (sb_done)
  );

  // ****************************************
  // registered outputs, taken from the next state so they align with it
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_en        <= 1'b0;
      wr_en        <= 1'b0;
      busy         <= 1'b1;
      nv_store_go  <= 1'b0;
      nv_recall_go <= 1'b0;
      sleep_mode   <= 1'b0;
    end else begin
      // no access while saving, restoring or under-voltage
      rd_en        <= (state_nxt == NVSC_IDLE) && sup_r;
      // writes outlive the trigger only through the short hold
      wr_en        <= ((state_nxt == NVSC_IDLE) && sup_r) || (state_nxt == NVSC_PF_HOLD);
      busy         <= (state_nxt != NVSC_IDLE) || !sup_r;
      nv_store_go  <= nv_store_go_now();
      nv_recall_go <= nv_recall_go_now();
      sleep_mode   <= (state_nxt == NVSC_SLEEP);
    end
  end

  // standby ends on the next start
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      standby_mode <= 1'b0;
    end else if (bus_start || (state_r != NVSC_IDLE)) begin
      standby_mode <= 1'b0;
    end else if (sb_done) begin
      standby_mode <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dirty <= 1'b0;
    end else begin
      dirty <= dirty_r;
    end
  end

endmodule

// ==== nvsc_ctrl_asserts.sv ====
// port checker of the store/recall controller
// assumes it is bound onto nvsc_ctrl and given the same cycle counts
`timescale 1ns/1ns
module nvsc_ctrl_asserts #(
  parameter int RECALL_UP_CYC = 20,
  parameter int STORE_CYC     = 16,
  parameter int RECALL_CYC    = 12,
  parameter int SLEEP_CYC     = 14,
  parameter int WAKE_CYC      = 18,
  parameter int STANDBY_CYC   = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // inputs
  input wire logic supply_ok,
  input wire logic bus_start,
  input wire logic bus_stop,
  input wire logic cmd_store,
  input wire logic cmd_recall,
  input wire logic cmd_sleep,
  // outputs
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic busy,
  input wire logic nv_store_go,
  input wire logic nv_recall_go,
  input wire logic sleep_mode,
  input wire logic standby_mode,
  input wire logic dirty
);
  // ****************
  // bounds
  // ****************
  localparam int RU = RECALL_UP_CYC + 1;
  localparam int SL = SLEEP_CYC + 1;
  localparam int WK = WAKE_CYC + 2;
  localparam int SB = STANDBY_CYC + 1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ****************
  // properties
  // ****************
  property p_store;
    (cmd_store && !busy) |=> (nv_store_go && busy && !rd_en) ##STORE_CYC (!busy && rd_en);
  endproperty
  property p_recall;
    (cmd_recall && !cmd_store && !busy) |=> nv_recall_go ##RECALL_CYC !busy;
  endproperty
  property p_sleep;
    (cmd_sleep && !cmd_store && !cmd_recall && !busy) |=> nv_store_go ##[1:SL] sleep_mode;
  endproperty
  property p_wake;
    (sleep_mode && bus_start) |=> busy ##[1:WK] !busy;
  endproperty
  property p_standby;
    (bus_stop && !busy) |-> ##SB standby_mode;
  endproperty
  property p_lock;
    busy |-> !rd_en;
  endproperty
  property p_low;
    (!supply_ok) [*8] |-> (busy && !rd_en);
  endproperty
  property p_hold;
    (busy && wr_en) |=> (!wr_en && nv_store_go);
  endproperty
  property p_clean;
    ($rose(busy) && !dirty && !nv_store_go && !nv_recall_go) |-> (!nv_store_go) [*8];
  endproperty
  property p_upr;
    $rose(nv_recall_go) |-> ##[1:RU] !busy;
  endproperty
  a_store: assert property (p_store) else $error("commanded save timing wrong");
  a_recall: assert property (p_recall) else $error("commanded restore wrong");
  a_sleep: assert property (p_sleep) else $error("sleep entry late");
  a_wake: assert property (p_wake) else $error("wake time wrong");
  a_standby: assert property (p_standby) else $error("standby late");
  a_lock: assert property (p_lock) else $error("read open while busy");
  a_low: assert property (p_low) else $error("access open on low supply");
  a_hold: assert property (p_hold) else $error("write window too long");
  a_clean: assert property (p_clean) else $error("save without writes");
  a_upr: assert property (p_upr) else $error("restore too long");
  c_store: cover property (cmd_store && !busy);
  c_wake: cover property (sleep_mode && bus_start);
  c_stby: cover property ($rose(standby_mode));
  c_pfail: cover property ($rose(busy) && wr_en);
endmodule

bind nvsc_ctrl nvsc_ctrl_asserts #(
  .RECALL_UP_CYC(RECALL_UP_CYC), .STORE_CYC(STORE_CYC), .RECALL_CYC(RECALL_CYC),
  .SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC), .STANDBY_CYC(STANDBY_CYC)
) u_chk (.core_clk, .rstn, .supply_ok, .bus_start, .bus_stop, .cmd_store, .cmd_recall,
  .cmd_sleep, .rd_en, .wr_en, .busy, .nv_store_go, .nv_recall_go, .sleep_mode, .standby_mode,
  .dirty);

// ==== nvsc_host_model.sv ====
// bus master model: one-cycle bus events toward the controller
// assumes the bench calls send and that busy is the controller's output
`timescale 1ns/1ns
module nvsc_host_model (
  // clock and status
  input  wire logic core_clk,
  input  wire logic busy,
  // bus events
  output logic      bus_start,
  output logic      bus_stop,
  output logic      cmd_store,
  output logic      cmd_recall,
  output logic      cmd_sleep,
  output logic      sram_wr_done
);
  logic [5:0] ev_r = 6'h00;
  assign {bus_start, bus_stop, cmd_store, cmd_recall, cmd_sleep, sram_wr_done} = ev_r;
  // a polite host waits out a busy interval of up to 5000 falling edges before the next access
  // an impolite call sends at once, for the wake and to prove that refused events are ignored
  task automatic send(input logic [5:0] ev, input bit polite);
    int n;
    n = 0;
    @(negedge core_clk);
    while (polite && busy !== 1'b0 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    ev_r = ev;
    @(negedge core_clk);
    ev_r = 6'h00;
  endtask
endmodule

// ==== tb_nvsc_ctrl.sv ====
// self-checking bench of the store/recall controller
// assumes the host model beside it and shortened cycle counts
`timescale 1ns/1ns
module tb_nvsc_ctrl;
  import nvsc_pkg::*;
  // ****************
  // counts and events
  // ****************
  localparam logic [CNT_W-1:0] RU = 20'h14, ST = 20'h10, RC = 20'h0C, SL = 20'h0E;
  localparam logic [CNT_W-1:0] WK = 20'h12, SB = 20'h0A, CA = 20'h08;
  localparam logic [5:0] EV_START = 6'h20, EV_STOP = 6'h10, EV_STORE = 6'h08;
  localparam logic [5:0] EV_RECALL = 6'h04, EV_SLEEP = 6'h02, EV_WR = 6'h01;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic supply_ok = 1'b1;
  logic bus_start, bus_stop, cmd_store, cmd_recall, cmd_sleep, sram_wr_done;
  logic rd_en, wr_en, busy, nv_store_go, nv_recall_go, sleep_mode, standby_mode, dirty;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  always #10 core_clk = ~core_clk;
  nvsc_ctrl #(.RECALL_UP_CYC(RU), .STORE_CYC(ST), .RECALL_CYC(RC),
    .CMD_ACT_CYC(CA), .SLEEP_CYC(SL), .WAKE_CYC(WK), .STANDBY_CYC(SB)
  ) dut (.core_clk, .rstn, .supply_ok, .bus_start, .bus_stop, .cmd_store, .cmd_recall,
    .cmd_sleep, .sram_wr_done, .rd_en, .wr_en, .busy, .nv_store_go, .nv_recall_go,
    .sleep_mode, .standby_mode, .dirty);
  nvsc_host_model host (.core_clk, .busy, .bus_start, .bus_stop, .cmd_store, .cmd_recall,
    .cmd_sleep, .sram_wr_done);
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // falling edges until the signal shows the level; bounded against hangs
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic t_busy(input logic [5:0] ev, input int exp);
    host.send(ev, 1'b1);
    wait_for(busy, 1'b1);
    wait_for(busy, 1'b0);
    check(n, exp);
    check({rd_en, wr_en}, 2'h3);
  endtask
  task automatic t_store;
    host.send(EV_WR, 1'b1);
    repeat (2) @(negedge core_clk);
    check(dirty, 1'b1);
    t_busy(EV_STORE, ST);
    check(dirty, 1'b0);
    t_busy(EV_RECALL, RC);
  endtask
  task automatic t_standby;
    host.send(EV_STOP, 1'b1);
    wait_for(standby_mode, 1'b1);
    check(n, SB);
    host.send(EV_START, 1'b1);
    @(negedge core_clk);
    check(standby_mode, 1'b0);
  endtask
  // the controller stays busy while asleep, so wake and the stray save go impolitely
  task automatic t_sleep;
    host.send(EV_SLEEP, 1'b1);
    wait_for(sleep_mode, 1'b1);
    check(n <= SL + 1, 1'b1);
    host.send(EV_STORE, 1'b0);
    repeat (3) @(negedge core_clk);
    check({sleep_mode, nv_store_go}, 2'h2);
    host.send(EV_START, 1'b0);
    wait_for(busy, 1'b0);
    check(n >= WK && n <= WK + 2, 1'b1);
  endtask
  task automatic t_pfail;
    host.send(EV_WR, 1'b1);
    repeat (2) @(negedge core_clk);
    supply_ok = 1'b0;
    wait_for(busy, 1'b1);
    check({rd_en, wr_en}, 2'h1);
    @(negedge core_clk);
    check({wr_en, nv_store_go}, 2'h1);
    host.send(EV_RECALL, 1'b0);
    repeat (ST + 4) @(negedge core_clk);
    check({busy, rd_en, wr_en}, 3'h4);
    supply_ok = 1'b1;
    wait_for(busy, 1'b0);
    check(n <= RU + 8, 1'b1);
    supply_ok = 1'b0;
    wait_for(busy, 1'b1);
    for (int i = 0; i < 8; i++) begin
      check({wr_en, nv_store_go}, 2'h0);
      @(negedge core_clk);
    end
    supply_ok = 1'b1;
    wait_for(busy, 1'b0);
    check(n <= RU + 8, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************
  // main sequence and hang guard
  // ****************
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    wait_for(busy, 1'b0);
    check(n <= RU + 8, 1'b1);
    t_store();
    t_standby();
    t_sleep();
    t_pfail();
    report_and_stop();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
endmodule
